// >>> verilog/pcm_stream_interleaver.sv
`timescale 1ns/1ps
module pcm_stream_interleaver (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic mux_timing_in,
  input wire logic first_stream_in,
  input wire logic second_stream_in,
  input wire interleaver_pkg::chan_mode_t mode,
  output logic substitute_train,
  output logic fault_loc_timing,
  output logic mixed_out,
  output interleaver_pkg::monitor_t monitor
);

  // ===========================================================================
  // Link domain declarations
  logic mux_l_sync0_reg;
  logic mux_l_sync0_next;
  logic mux_l_sync1_reg;
  logic mux_l_sync1_next;
  logic mux_l_prev_reg;
  logic mux_l_prev_next;
  logic div1_reg;
  logic div1_next;
  logic div2_reg;
  logic div2_next;
  wire set_pulse_l;

  // ===========================================================================
  // System domain declarations
  wire [6:0] async_in;
  wire [6:0] synced;
  wire div1_s;
  wire div2_s;
  wire mux_s;
  wire first_s;
  wire second_s;
  wire [1:0] mode_s;
  logic div1_prev_reg;
  logic div1_prev_next;
  logic div2_prev_reg;
  logic div2_prev_next;
  logic mux_prev_reg;
  logic mux_prev_next;
  logic toggle_reg;
  logic toggle_next;
  logic fault_reg;
  logic fault_next;
  logic half2_reg;
  logic half2_next;
  logic substitute_next;
  logic fault_loc_next;
  logic mixed_next;
  interleaver_pkg::monitor_t monitor_next;

  // ===========================================================================
  // Decode declarations
  wire sq1152_rise;
  wire sq576_rise;
  wire mux_rise;
  wire mux_fall;
  wire high_rate;
  wire path_on;
  wire strobe2;
  wire first_samp;
  wire mix_value;

  // ===========================================================================
  // Link domain: multiplex timing synchroniser
  assign mux_l_sync0_next = mux_timing_in;
  assign mux_l_sync1_next = mux_l_sync0_reg;
  assign mux_l_prev_next = mux_l_sync1_reg;
  assign set_pulse_l = mux_l_prev_reg & ~mux_l_sync1_reg;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_l_sync0_reg <= 1'b0;
    end else begin
      mux_l_sync0_reg <= mux_l_sync0_next;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_l_sync1_reg <= 1'b0;
    end else begin
      mux_l_sync1_reg <= mux_l_sync1_next;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_l_prev_reg <= 1'b0;
    end else begin
      mux_l_prev_reg <= mux_l_prev_next;
    end
  end

  // ===========================================================================
  // Link domain: divider chain
  always_comb begin
    div1_next = ~div1_reg;
    if (set_pulse_l) begin
      div1_next = interleaver_pkg::DIV1_PRESET;
    end
  end

  always_comb begin
    div2_next = div2_reg;
    if (set_pulse_l) begin
      div2_next = interleaver_pkg::DIV2_PRESET;
    end else if (!div1_reg) begin
      div2_next = ~div2_reg;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      div1_reg <= 1'b0;
    end else begin
      div1_reg <= div1_next;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      div2_reg <= 1'b0;
    end else begin
      div2_reg <= div2_next;
    end
  end

  // ===========================================================================
  // Two-flop synchronisers into the system clock
  assign async_in = {
    mode,
    second_stream_in,
    first_stream_in,
    mux_timing_in,
    div2_reg,
    div1_reg
  };

  for (genvar gi = 0; gi < 7; gi++) begin : g_sync
    logic stage0_reg;
    logic stage1_reg;

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        stage0_reg <= 1'b0;
      end else begin
        stage0_reg <= async_in[gi];
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        stage1_reg <= 1'b0;
      end else begin
        stage1_reg <= stage0_reg;
      end
    end

    assign synced[gi] = stage1_reg;
  end

  assign div1_s = synced[0];
  assign div2_s = synced[1];
  assign mux_s = synced[2];
  assign first_s = synced[3];
  assign second_s = synced[4];
  assign mode_s = synced[6:5];

  // ===========================================================================
  // Edge detect history
  assign div1_prev_next = div1_s;
  assign div2_prev_next = div2_s;
  assign mux_prev_next = mux_s;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div1_prev_reg <= 1'b0;
    end else begin
      div1_prev_reg <= div1_prev_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div2_prev_reg <= 1'b0;
    end else begin
      div2_prev_reg <= div2_prev_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_prev_reg <= 1'b0;
    end else begin
      mux_prev_reg <= mux_prev_next;
    end
  end

  // ===========================================================================
  // Decode
  assign sq1152_rise = div1_s & ~div1_prev_reg;
  assign sq576_rise = div2_s & ~div2_prev_reg;
  assign mux_rise = mux_s & ~mux_prev_reg;
  assign mux_fall = mux_prev_reg & ~mux_s;
  assign high_rate = (mode_s == interleaver_pkg::MODE_HIGH);
  assign path_on = ~high_rate;
  assign strobe2 = sq576_rise & second_s;
  assign first_samp = path_on & first_s & ~div2_s;
  assign mix_value = first_samp | half2_reg;

  // ===========================================================================
  // Substitute and fault-location dividers
  always_comb begin
    toggle_next = toggle_reg;
    if (mux_rise) begin
      toggle_next = ~toggle_reg;
    end
  end

  always_comb begin
    fault_next = fault_reg;
    if (mux_rise && high_rate) begin
      fault_next = ~fault_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= toggle_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ===========================================================================
  // Half-width second stream
  always_comb begin
    half2_next = half2_reg;
    if (!path_on) begin
      half2_next = 1'b0;
    end else if (strobe2) begin
      half2_next = 1'b1;
    end else if (sq1152_rise) begin
      half2_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half2_reg <= 1'b0;
    end else begin
      half2_reg <= half2_next;
    end
  end

  // ===========================================================================
  // Output values
  always_comb begin
    substitute_next = 1'b0;
    if (path_on) begin
      substitute_next = toggle_reg;
    end
  end

  always_comb begin
    fault_loc_next = 1'b0;
    if (high_rate) begin
      fault_loc_next = fault_reg;
    end
  end

  always_comb begin
    mixed_next = mix_value;
  end

  always_comb begin
    monitor_next = '0;
    monitor_next.mixed = mix_value;
    monitor_next.first = first_samp;
    monitor_next.second = half2_reg;
    monitor_next.set_timing = mux_fall;
  end

  // ===========================================================================
  // Output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      substitute_train <= 1'b0;
    end else begin
      substitute_train <= substitute_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_loc_timing <= 1'b0;
    end else begin
      fault_loc_timing <= fault_loc_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mixed_out <= 1'b0;
    end else begin
      mixed_out <= mixed_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor <= '0;
    end else begin
      monitor <= monitor_next;
    end
  end

endmodule // pcm_stream_interleaver

// >>> verilog/interleaver_pkg.sv
// Function
// - 12/24-channel modes: halve multiplex timing into the substitute train.
// - Substitute train is a 288 kc toggle square wave on its own output.
// - In high-rate mode, halved timing (1,152 kc) feeds only fault location.
// - Interleaving path runs only in 12- and 24-channel modes.
// - Substitute train interleaves in 12-channel mode or when the first stream fails.
// - First divider halves 2,304 kc timing, preset to multiplex timing phase.
// - Second divider halves 1,152 kc to 576 kc, preset by the same pulses.
// - Each multiplex timing falling edge sets both dividers.
// - First stream sampled by 576 kc wave; a one passes only while low.
// - Strobe on each 576 kc rising edge passes while second input high.
// - A passed strobe sets the half-width second-stream flip-flop.
// - Half-width flip-flop clears on 1,152 kc rising edges with no passed strobe, and in high-rate mode.
// - Mixed output is OR of sampled first and half-width second stream.
// - Separate observation copies of mixed, first, second and set timing.
package interleaver_pkg;

  // ===========================================================================
  // Timing
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned XMIT_TIMING_KC = 2304;
  localparam int unsigned SYNC_STAGES = 2;

  // ===========================================================================
  // Divider preset values
  localparam logic DIV1_PRESET = 1'b1;
  localparam logic DIV2_PRESET = 1'b1;

  // ===========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_12CH = 2'b00,
    MODE_24CH = 2'b01,
    MODE_HIGH = 2'b11
  } chan_mode_t;

  typedef struct packed {
    logic mixed;
    logic first;
    logic second;
    logic set_timing;
  } monitor_t;

endpackage

// >>> dv/ilv_asserts.sv
`timescale 1ns/1ps
// ==========
// Interleaver checks
module ilv_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic mux_timing_in,
  input wire logic first_stream_in,
  input wire logic second_stream_in,
  input wire logic substitute_train,
  input wire logic fault_loc_timing,
  input wire logic mixed_out,
  input wire interleaver_pkg::chan_mode_t mode,
  input wire interleaver_pkg::monitor_t monitor
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire hi = mode == interleaver_pkg::MODE_HIGH;
  a_high_no_sub: assert property (hi [*5] |-> !substitute_train)
    else $error("sub in high rate");
  a_high_no_mix: assert property (hi [*5] |-> !mixed_out)
    else $error("mix in high rate");
  a_high_no_mon: assert property (hi [*5] |-> !monitor.second)
    else $error("second in high rate");
  a_low_no_fault: assert property ((!hi) [*5] |-> !fault_loc_timing)
    else $error("fault timing in low rate");
  a_mon_copy: assert property (monitor.mixed == mixed_out)
    else $error("mixed copy differs");
  a_mix_or: assert property (
    mixed_out == (monitor.first | monitor.second))
    else $error("mixed not the OR of both streams");
  a_set_single: assert property (
    monitor.set_timing |=> !monitor.set_timing)
    else $error("set pulse too long");
  a_sub_rate: assert property ($rose(substitute_train) |=>
    substitute_train [*8] ##[8:14] !substitute_train) else $error("sub rate");
  a_fault_rate: assert property ($rose(fault_loc_timing) |=>
    fault_loc_timing [*3] ##[1:3] !fault_loc_timing) else $error("fault rate");
  c_mix: cover property ($rose(mixed_out));
  c_flt: cover property ($rose(fault_loc_timing));
  c_set: cover property (monitor.set_timing);
endmodule // ilv_asserts
bind pcm_stream_interleaver ilv_asserts chk (.*);

// >>> dv/panel_model.sv
`timescale 1ns/1ps
// ==========
// Transmit panel stand-in
module panel_model (
  input wire logic link_clk,
  input wire logic fail1,
  input wire logic sub,
  input wire interleaver_pkg::chan_mode_t mode,
  output logic mux,
  output logic s1,
  output logic s2
);
  logic [3:0] cnt_reg = 4'h0;
  wire low = mode != interleaver_pkg::MODE_HIGH;
  wire twelve = mode == interleaver_pkg::MODE_12CH;
  always @(posedge link_clk) cnt_reg <= cnt_reg + 4'h1;
  assign mux = low ? cnt_reg[1] : link_clk;
  assign s1 = fail1 ? sub : cnt_reg[2];
  assign s2 = twelve ? sub : cnt_reg[3];
endmodule // panel_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ==========
// Bench top
module testbench;
  logic clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, f1 = 1'b0;
  interleaver_pkg::chan_mode_t mode = interleaver_pkg::MODE_24CH;
  logic mux_timing_in, first_stream_in, second_stream_in;
  logic substitute_train, fault_loc_timing, mixed_out;
  interleaver_pkg::monitor_t monitor;
  int fail_count = 0, tests_run = 0;
  logic [7:0] n [5] = '{default: 8'h00};
  logic [7:0] d [5];
  initial forever #5 clk = ~clk;
  initial forever #24 link_clk = ~link_clk;
  panel_model pm (.link_clk(link_clk), .fail1(f1), .sub(substitute_train),
    .mode(mode), .mux(mux_timing_in), .s1(first_stream_in),
    .s2(second_stream_in));
  pcm_stream_interleaver uut (.*);
  always @(posedge clk) begin
    n[0] <= n[0] + {7'h00, $rose(substitute_train)};
    n[1] <= n[1] + {7'h00, $rose(fault_loc_timing)};
    n[2] <= n[2] + {7'h00, monitor.set_timing};
    n[3] <= n[3] + {7'h00, $rose(monitor.second)};
    n[4] <= n[4] + {7'h00, $rose(monitor.first)};
  end
  task automatic chk(input string nm, input logic [7:0] lo, hi, got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask
  task automatic run(input interleaver_pkg::chan_mode_t m, input logic f);
    logic [7:0] s [5];
    @(posedge clk);
    #1 arst_n = 1'b0;
    mode = m;
    f1 = f;
    repeat (16) @(posedge clk);
    chk("rst", 8'h00, 8'h00, {6'h00, substitute_train, mixed_out});
    #1 arst_n = 1'b1;
    repeat (60) @(posedge clk);
    s = n;
    repeat (480) @(posedge clk);
    foreach (d[i]) d[i] = n[i] - s[i];
  endtask
  task t_24ch;
    run(interleaver_pkg::MODE_24CH, 1'b0);
    chk("sub", 8'h0B, 8'h0E, d[0]);
    chk("flt", 8'h00, 8'h00, d[1]);
    chk("set", 8'h18, 8'h1A, d[2]);
    chk("sec", 8'h0B, 8'h0E, d[3]);
    chk("fst", 8'h0B, 8'h0E, d[4]);
  endtask
  task t_12ch;
    run(interleaver_pkg::MODE_12CH, 1'b1);
    chk("sub12", 8'h0B, 8'h0E, d[0]);
    chk("sec12", 8'h0B, 8'h0E, d[3]);
  endtask
  task t_high;
    run(interleaver_pkg::MODE_HIGH, 1'b0);
    chk("fltH", 8'h31, 8'h33, d[1]);
    chk("subH", 8'h00, 8'h00, d[0]);
    chk("secH", 8'h00, 8'h00, d[3]);
    chk("fstH", 8'h00, 8'h00, d[4]);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    t_24ch();
    t_12ch();
    t_high();
    stop_test();
  end
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule // testbench
